// [core/lkf_pkg.sv]
package lkf_pkg;

    // ==========================================================
    // key geometry
    // ==========================================================
    // widest key, double v6, sets the stored key width
    localparam int KEY_W = 256;
    // key widths in bits per key type
    localparam int KW_SINGLE_V4 = 33;
    localparam int KW_DOUBLE_V4 = 64;
    localparam int KW_SINGLE_V6 = 129;
    localparam int KW_DOUBLE_V6 = 256;
    // store words taken per key type
    localparam int WORDS_SINGLE_V4 = 1;
    localparam int WORDS_DOUBLE_V4 = 2;
    localparam int WORDS_SINGLE_V6 = 4;
    localparam int WORDS_DOUBLE_V6 = 8;
    // direction flag position and values in single keys
    localparam int DIR_FLAG_POS = 0;
    localparam logic DIR_SOURCE = 1'b0;
    localparam logic DIR_DEST = 1'b1;
    // address widths
    localparam int V4_W = 32;
    localparam int V6_W = 128;
    // prefix length field width, up to 256
    localparam int PLEN_W = 9;

    // ==========================================================
    // action geometry
    // ==========================================================
    localparam int ACT_W = 62;
    localparam int ACT_TYPE_POS = 0;
    // neighbour pointer action, 18 bits
    localparam int NP_PTR_POS = 2;
    localparam int NP_REMAP_POS = 10;
    localparam int NP_PATHS_POS = 11;
    localparam int NP_GROUP_POS = 15;
    localparam int NP_SIZE = 18;
    // multicast pointer action, 10 bits
    localparam int MP_PTR_POS = 2;
    localparam int MP_SIZE = 10;
    // inline neighbour entry action, 62 bits
    localparam int NE_MAC_HI_POS = 2;
    localparam int NE_MAC_LO_POS = 18;
    localparam int NE_LEG_POS = 50;
    localparam int NE_QUEUE_POS = 55;
    localparam int NE_RPF_POS = 58;
    localparam int NE_VMID_POS = 59;
    localparam int NE_MACM_POS = 60;
    localparam int NE_ENA_POS = 61;

    // ==========================================================
    // types
    // ==========================================================
    typedef enum logic [1:0] {
        SINGLE_V4_KEY,
        DOUBLE_V4_KEY,
        SINGLE_V6_KEY,
        DOUBLE_V6_KEY
    } lkf_key_type_t;

    // order gives the action type codes 0..3
    typedef enum logic [1:0] {
        ACT_NBR_POINTER,
        ACT_MULTICAST_POINTER,
        ACT_NBR_ENTRY,
        ACT_RESERVED
    } lkf_act_type_t;

    // one store entry as software writes it
    typedef struct packed {
        logic valid;
        lkf_key_type_t key_type;
        logic [PLEN_W-1:0] prefix_len;
        logic [KEY_W-1:0] key;
        logic [ACT_W-1:0] action;
    } lkf_entry_t;

    // one frame's addresses from the lookup stage
    typedef struct packed {
        logic is_v6;
        logic is_mc;
        logic [V6_W-1:0] src_addr;
        logic [V6_W-1:0] dst_addr;
    } lkf_lookup_t;

    // decoded action fields
    typedef struct packed {
        lkf_act_type_t act_type;
        logic [7:0] nbr_pointer;
        logic remap_enable;
        logic [3:0] equal_cost_path_count;
        logic [2:0] route_group_id;
        logic [7:0] multicast_pointer;
        logic [15:0] mac_upper;
        logic [31:0] mac_lower;
        logic [4:0] router_leg_id;
        logic [2:0] zero_dmac_cpu_queue;
        logic reverse_path_check_enable;
        logic vmid_security_match;
        logic mac_security_match;
        logic entry_enable;
    } lkf_action_t;

    // one lookup answer
    typedef struct packed {
        logic hit;
        logic usable;
        logic [7:0] index;
        lkf_key_type_t key_type;
        lkf_action_t action;
    } lkf_result_t;

endpackage : lkf_pkg

// [core/lkf_prefix_store.sv]
`timescale 1ns/1ps

// Operation
// (R1) one store holds keys and their actions
// (R2) four key types with fixed sizes
// (R3) software packs key fields from bit 0
// (R4) single v4: flag bit 0, address above
// (R5) flag 0 source only, 1 destination only
// (R6) single v6: flag, then 128-bit address
// (R7) double v4: source then destination, no flag
// (R8) double v6: source then destination, no flag
// (R9) action opens with 2-bit type code
// (R10) software packs action fields from bit 0
// (R11) neighbour pointer, 18 bits, single keys only
// (R12) 8-bit neighbour pointer follows type
// (R13) remap enable redirects pointer to remap table
// (R14) 4-bit equal-cost path count follows
// (R15) 3-bit route group for reverse-path check
// (R16) multicast pointer, 10 bits, double keys only
// (R17) inline neighbour entry, 62 bits, single keys
// (R18) two lookups per frame, source and destination
// (R19) hit yields neighbour index for guard checks
// (R20) longest prefix wins, miss when none match
// (R21) reserved action type gives no usable result
module lkf_prefix_store #(
    parameter int ENTRIES = 16
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [$clog2(ENTRIES)-1:0] wr_index,
    input wire lkf_pkg::lkf_entry_t wr_entry,
    input wire logic lk_req,
    input wire lkf_pkg::lkf_lookup_t lk_in,
    output logic lk_done,
    output lkf_pkg::lkf_result_t src_result,
    output lkf_pkg::lkf_result_t dst_result
);

    localparam int IDX_W = $clog2(ENTRIES);

    // ==========================================================
    // helper functions
    // ==========================================================
    // key width of a type; the enum leaves no illegal code
    // (R2) four key types, fixed widths
    function automatic int key_width(lkf_pkg::lkf_key_type_t kt);
        unique case (kt)
            lkf_pkg::SINGLE_V4_KEY: return lkf_pkg::KW_SINGLE_V4;
            lkf_pkg::DOUBLE_V4_KEY: return lkf_pkg::KW_DOUBLE_V4;
            lkf_pkg::SINGLE_V6_KEY: return lkf_pkg::KW_SINGLE_V6;
            lkf_pkg::DOUBLE_V6_KEY: return lkf_pkg::KW_DOUBLE_V6;
        endcase
    endfunction : key_width
    // single keys carry the direction flag
    function automatic logic is_single(lkf_pkg::lkf_key_type_t kt);
        return kt inside {lkf_pkg::SINGLE_V4_KEY, lkf_pkg::SINGLE_V6_KEY};
    endfunction : is_single
    // prefix compare: top plen bits cared, flag always cared
    function automatic logic entry_match(
        input lkf_pkg::lkf_entry_t ent,
        input lkf_pkg::lkf_key_type_t kt,
        input logic [lkf_pkg::KEY_W-1:0] key
    );
        int kw;
        int lo;
        logic ok;
        kw = key_width(ent.key_type);
        lo = kw - int'(ent.prefix_len);
        ok = ent.valid && (ent.key_type == kt);
        for (int i = 0; i < lkf_pkg::KEY_W; i++)
        begin
            // (R5) flag must equal the lookup's direction
            if ((i < kw) && ((i >= lo) ||
                (is_single(kt) && i == lkf_pkg::DIR_FLAG_POS)))
            begin
                ok = ok & (ent.key[i] == key[i]);
            end
        end
        return ok;
    endfunction : entry_match
    // unpack action bits into named fields
    function automatic lkf_pkg::lkf_action_t decode_action(
        input logic [lkf_pkg::ACT_W-1:0] a
    );
        lkf_pkg::lkf_action_t d;
        // (R9) type code in the low two bits
        d.act_type = lkf_pkg::lkf_act_type_t'(a[lkf_pkg::ACT_TYPE_POS +: 2]);
        // (R12) neighbour pointer after the type
        d.nbr_pointer = a[lkf_pkg::NP_PTR_POS +: 8];
        // (R13) remap enable after the pointer
        d.remap_enable = a[lkf_pkg::NP_REMAP_POS];
        // (R14) equal-cost path count
        d.equal_cost_path_count = a[lkf_pkg::NP_PATHS_POS +: 4];
        // (R15) route group closes the pointer action
        d.route_group_id = a[lkf_pkg::NP_GROUP_POS +: 3];
        // (R16) multicast table pointer
        d.multicast_pointer = a[lkf_pkg::MP_PTR_POS +: 8];
        // (R17) inline neighbour entry fields
        d.mac_upper = a[lkf_pkg::NE_MAC_HI_POS +: 16];
        d.mac_lower = a[lkf_pkg::NE_MAC_LO_POS +: 32];
        d.router_leg_id = a[lkf_pkg::NE_LEG_POS +: 5];
        d.zero_dmac_cpu_queue = a[lkf_pkg::NE_QUEUE_POS +: 3];
        d.reverse_path_check_enable = a[lkf_pkg::NE_RPF_POS];
        d.vmid_security_match = a[lkf_pkg::NE_VMID_POS];
        d.mac_security_match = a[lkf_pkg::NE_MACM_POS];
        d.entry_enable = a[lkf_pkg::NE_ENA_POS];
        return d;
    endfunction : decode_action
    // build an answer; usable only for a legal type/key pairing
    function automatic lkf_pkg::lkf_result_t make_result(
        input logic hit,
        input logic [7:0] idx,
        input lkf_pkg::lkf_entry_t ent
    );
        lkf_pkg::lkf_result_t r;
        logic fits;
        r.hit = hit;
        r.index = hit ? idx : 8'h00;
        r.key_type = ent.key_type;
        r.action = decode_action(ent.action);
        unique case (r.action.act_type)
            // (R11) pointer action only behind single keys
            lkf_pkg::ACT_NBR_POINTER: fits = is_single(ent.key_type);
            // (R16) multicast pointer only behind double keys
            lkf_pkg::ACT_MULTICAST_POINTER: fits = !is_single(ent.key_type);
            // (R17) inline entry only behind single keys
            lkf_pkg::ACT_NBR_ENTRY: fits = is_single(ent.key_type);
            // (R21) reserved code is never followed
            lkf_pkg::ACT_RESERVED: fits = 1'b0;
        endcase
        r.usable = hit && fits;
        return r;
    endfunction : make_result

    // ==========================================================
    // entry store
    // ==========================================================
    // entries, written whole by software
    lkf_pkg::lkf_entry_t store_q [ENTRIES];

    // (R1) keys and actions kept side by side
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            for (int e = 0; e < ENTRIES; e++)
            begin
                store_q[e].valid <= 1'b0;
            end
        end
        // (R3) key image stored as packed by software
        else if (wr_en)
        begin
            store_q[wr_index] <= wr_entry;
        end
    end

    // ==========================================================
    // lookup key formation
    // ==========================================================
    lkf_pkg::lkf_key_type_t src_kt; // source lookup key type
    lkf_pkg::lkf_key_type_t dst_kt; // destination lookup key type
    logic [lkf_pkg::KEY_W-1:0] src_key; // source lookup key image
    logic [lkf_pkg::KEY_W-1:0] dst_key; // destination lookup key image

    // (R18) source key, and destination or both for multicast
    always_comb
    begin
        src_key = '0;
        dst_key = '0;
        if (lk_in.is_v6)
        begin
            // (R6) flag then 128-bit address
            src_kt = lkf_pkg::SINGLE_V6_KEY;
            src_key[lkf_pkg::V6_W:0] = {lk_in.src_addr, lkf_pkg::DIR_SOURCE};
            if (lk_in.is_mc)
            begin
                // (R8) source low, destination high
                dst_kt = lkf_pkg::DOUBLE_V6_KEY;
                dst_key = {lk_in.dst_addr, lk_in.src_addr};
            end
            else
            begin
                dst_kt = lkf_pkg::SINGLE_V6_KEY;
                dst_key[lkf_pkg::V6_W:0] = {lk_in.dst_addr, lkf_pkg::DIR_DEST};
            end
        end
        else
        begin
            // (R4) flag at bit 0, v4 address above
            src_kt = lkf_pkg::SINGLE_V4_KEY;
            src_key[lkf_pkg::V4_W:0] =
                {lk_in.src_addr[lkf_pkg::V4_W-1:0], lkf_pkg::DIR_SOURCE};
            if (lk_in.is_mc)
            begin
                // (R7) source low, destination high
                dst_kt = lkf_pkg::DOUBLE_V4_KEY;
                dst_key[2*lkf_pkg::V4_W-1:0] =
                    {lk_in.dst_addr[lkf_pkg::V4_W-1:0],
                     lk_in.src_addr[lkf_pkg::V4_W-1:0]};
            end
            else
            begin
                dst_kt = lkf_pkg::SINGLE_V4_KEY;
                dst_key[lkf_pkg::V4_W:0] =
                    {lk_in.dst_addr[lkf_pkg::V4_W-1:0], lkf_pkg::DIR_DEST};
            end
        end
    end

    // ==========================================================
    // per-entry compare and longest-prefix pick
    // ==========================================================
    logic [ENTRIES-1:0] src_hit_vec; // entries matching source key
    logic [ENTRIES-1:0] dst_hit_vec; // entries matching dest key

    // both lookups compare in parallel, one cycle per frame
    for (genvar g = 0; g < ENTRIES; g++)
    begin : g_cmp
        assign src_hit_vec[g] = entry_match(store_q[g], src_kt, src_key);
        assign dst_hit_vec[g] = entry_match(store_q[g], dst_kt, dst_key);
    end

    logic src_found; // any source match
    logic dst_found; // any destination match
    logic [IDX_W-1:0] src_best; // winning source entry
    logic [IDX_W-1:0] dst_best; // winning destination entry
    logic [lkf_pkg::PLEN_W-1:0] src_len; // winning source length
    logic [lkf_pkg::PLEN_W-1:0] dst_len; // winning destination length

    // (R20) longest prefix wins; equal length goes to lower index
    always_comb
    begin
        src_found = 1'b0;
        dst_found = 1'b0;
        src_best = '0;
        dst_best = '0;
        src_len = '0;
        dst_len = '0;
        for (int e = 0; e < ENTRIES; e++)
        begin
            if (src_hit_vec[e] &&
                (!src_found || store_q[e].prefix_len > src_len))
            begin
                src_found = 1'b1;
                src_best = IDX_W'(e);
                src_len = store_q[e].prefix_len;
            end
            if (dst_hit_vec[e] &&
                (!dst_found || store_q[e].prefix_len > dst_len))
            begin
                dst_found = 1'b1;
                dst_best = IDX_W'(e);
                dst_len = store_q[e].prefix_len;
            end
        end
    end

    // ==========================================================
    // answer registers
    // ==========================================================
    // done pulse one cycle after the request
    always_ff @(posedge clk_sys)
    begin
        lk_done <= !rst && lk_req;
    end

    // (R19) answers hold across frames until the next request
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            src_result <= '0;
            dst_result <= '0;
        end
        else if (lk_req)
        begin
            // (R20) a miss still answers, with hit low
            src_result <= make_result(src_found, 8'(src_best),
                store_q[src_best]);
            dst_result <= make_result(dst_found, 8'(dst_best),
                store_q[dst_best]);
        end
    end

    // ==========================================================
    // checks
    // ==========================================================
    a_done_timing: assert property ( // (R18)
        @(posedge clk_sys) disable iff (rst) lk_req |=> lk_done)
        else $error("lookup request not answered next cycle");
    a_done_cause: assert property ( // (R18)
        @(posedge clk_sys) disable iff (rst) lk_done |-> $past(lk_req))
        else $error("done pulse without a request");
    a_reserved_unusable: assert property ( // (R21)
        @(posedge clk_sys) disable iff (rst)
        dst_result.action.act_type == lkf_pkg::ACT_RESERVED
        |-> !dst_result.usable)
        else $error("reserved action reported usable");
    a_miss_unusable: assert property ( // (R20)
        @(posedge clk_sys) disable iff (rst)
        lk_done && !src_result.hit |-> !src_result.usable)
        else $error("miss reported usable");
    a_mc_double_only: assert property ( // (R16)
        @(posedge clk_sys) disable iff (rst)
        dst_result.usable && dst_result.action.act_type ==
        lkf_pkg::ACT_MULTICAST_POINTER |-> !is_single(dst_result.key_type))
        else $error("multicast pointer used behind single key");
    a_nbr_single_only: assert property ( // (R11)
        @(posedge clk_sys) disable iff (rst)
        dst_result.usable && !is_single(dst_result.key_type) |->
        dst_result.action.act_type == lkf_pkg::ACT_MULTICAST_POINTER)
        else $error("neighbour action used behind double key");
    a_dst_mc_double: assert property ( // (R18)
        @(posedge clk_sys) disable iff (rst)
        lk_req && lk_in.is_mc |=>
        !dst_result.hit || !is_single(dst_result.key_type))
        else $error("multicast lookup hit a single key");
    a_v4_family: assert property ( // (R4)
        @(posedge clk_sys) disable iff (rst)
        lk_req && !lk_in.is_v6 |=>
        !src_result.hit || src_result.key_type == lkf_pkg::SINGLE_V4_KEY)
        else $error("v4 source lookup hit another key type");
    a_src_hit_valid: assert property ( // (R1)
        @(posedge clk_sys) disable iff (rst)
        lk_req && !(|src_hit_vec) |=> !src_result.hit)
        else $error("source hit without any matching entry");

    c_src_usable: cover property (@(posedge clk_sys) disable iff (rst)
        lk_done && src_result.usable);
    c_dst_multicast: cover property (@(posedge clk_sys) disable iff (rst)
        lk_done && dst_result.usable && !is_single(dst_result.key_type));
    c_reserved_hit: cover property (@(posedge clk_sys) disable iff (rst)
        lk_done && dst_result.hit && !dst_result.usable);
    c_both_miss: cover property (@(posedge clk_sys) disable iff (rst)
        lk_done && !src_result.hit && !dst_result.hit);

endmodule : lkf_prefix_store

// [sim/lkf_sw_model.sv]
`timescale 1ns/1ps

// ==========================================================
// stand-in for software and the lookup stage
// ==========================================================
module lkf_sw_model #(
    parameter int ENTRIES = 16
) (
    input wire logic clk_sys,
    output logic wr_en,
    output logic [$clog2(ENTRIES)-1:0] wr_index,
    output lkf_pkg::lkf_entry_t wr_entry,
    output logic lk_req,
    output lkf_pkg::lkf_lookup_t lk_in
);
    // idle values at time zero
    initial
    begin
        wr_en = 1'b0;
        wr_index = '0;
        wr_entry = '0;
        lk_req = 1'b0;
        lk_in = '0;
    end

    // single key image, flag at bit 0
    function automatic logic [255:0] skey(logic f, logic [127:0] a);
        skey = {127'h0, a, f};
    endfunction : skey

    // double key image, source below destination
    function automatic logic [255:0] dkey(logic v6, logic [127:0] s,
                                          logic [127:0] d);
        dkey = v6 ? {d, s} : {192'h0, d[31:0], s[31:0]};
    endfunction : dkey

    // neighbour pointer action, 18 bits from bit 0
    function automatic logic [61:0] a_np(logic [7:0] p, logic r,
                                         logic [3:0] n, logic [2:0] g);
        a_np = {44'h0, g, n, r, p, 2'h0};
    endfunction : a_np

    // multicast pointer action, or reserved code
    function automatic logic [61:0] a_mc(logic [1:0] t, logic [7:0] p);
        a_mc = {52'h0, p, t};
    endfunction : a_mc

    // inline entry, flags {ena, mac, vmid, rpf}
    function automatic logic [61:0] a_ne(logic [15:0] h, logic [31:0] l,
                                         logic [4:0] v, logic [2:0] q,
                                         logic [3:0] f);
        a_ne = {f, q, v, l, h, 2'h2};
    endfunction : a_ne

    // one whole entry per write; data scrambled once released
    task automatic put(logic [$clog2(ENTRIES)-1:0] i,
                       lkf_pkg::lkf_key_type_t kt, logic [8:0] pl,
                       logic [255:0] k, logic [61:0] a);
        @(negedge clk_sys);
        wr_en = 1'b1;
        wr_index = i;
        wr_entry = {1'b1, kt, pl, k, a};
        @(negedge clk_sys);
        wr_en = 1'b0;
        wr_entry = ~wr_entry;
    endtask : put

    // one frame request; held across exactly one rising edge
    task automatic ask(logic v6, logic mc, logic [127:0] s,
                       logic [127:0] d);
        @(negedge clk_sys);
        lk_req = 1'b1;
        lk_in = {v6, mc, s, d};
        @(negedge clk_sys);
        lk_req = 1'b0;
        lk_in = ~lk_in;
    endtask : ask
endmodule : lkf_sw_model

// [sim/testbench.sv]
`timescale 1ns/1ps

// ==========================================================
// self-checking bench
// ==========================================================
module testbench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic wr_en;
    logic [3:0] wr_index;
    lkf_pkg::lkf_entry_t wr_entry;
    logic lk_req;
    lkf_pkg::lkf_lookup_t lk_in;
    logic lk_done;
    lkf_pkg::lkf_result_t sr;
    lkf_pkg::lkf_result_t dr;
    int bad_count = 0;
    int check_count = 0;
    // sample v6 addresses
    localparam logic [127:0] V6A =
        128'h2001_0db8_0000_0000_0000_0000_0000_0001;
    localparam logic [127:0] V6B =
        128'hff0e_0000_0000_0000_0000_0000_0000_00a5;

    // 125 MHz system clock
    always #4 clk_sys = ~clk_sys;

    lkf_prefix_store #(.ENTRIES(16)) u_dut (
        .clk_sys(clk_sys), .rst(rst), .wr_en(wr_en),
        .wr_index(wr_index), .wr_entry(wr_entry), .lk_req(lk_req),
        .lk_in(lk_in), .lk_done(lk_done), .src_result(sr),
        .dst_result(dr)
    );

    lkf_sw_model #(.ENTRIES(16)) u_sw (
        .clk_sys(clk_sys), .wr_en(wr_en), .wr_index(wr_index),
        .wr_entry(wr_entry), .lk_req(lk_req), .lk_in(lk_in)
    );

    // compare helper, four-state exact
    task automatic chk(logic [127:0] seen, logic [127:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    // verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    // lookup, then check done is high one cycle after the request
    task automatic look(logic v6, logic mc, logic [127:0] s,
                        logic [127:0] d);
        u_sw.ask(v6, mc, s, d);
        chk(lk_done, 1'b1);
    endtask : look

    // watchdog: whole run is some 36 cycles
    initial
    begin
        #50000;
        bad_count++;
        conclude();
    end

    // ======================================================
    // main sequence
    // ======================================================
    initial
    begin
        repeat (5) @(negedge clk_sys);
        rst = 1'b0;
        // empty store: nothing matches
        look(1'b0, 1'b0, 128'h0a01_0207, 128'h0a01_0207);
        chk(sr.hit, 1'b0);
        chk(dr.index, 8'h00);
        @(negedge clk_sys);
        chk(lk_done, 1'b0);
        // short and long source prefixes, reserved dest entry
        u_sw.put(4'h3, lkf_pkg::SINGLE_V4_KEY, 9'h018,
                 u_sw.skey(1'b0, 128'h0a01_0200),
                 u_sw.a_np(8'h5a, 1'b1, 4'h9, 3'h5));
        u_sw.put(4'h7, lkf_pkg::SINGLE_V4_KEY, 9'h021,
                 u_sw.skey(1'b0, 128'h0a01_0207),
                 u_sw.a_np(8'hc3, 1'b0, 4'h2, 3'h6));
        u_sw.put(4'h2, lkf_pkg::SINGLE_V4_KEY, 9'h021,
                 u_sw.skey(1'b1, 128'h0a01_0207), u_sw.a_mc(2'h3, 8'h11));
        look(1'b0, 1'b0, 128'h0a01_0207, 128'h0a01_0207);
        chk(sr.index, 8'h07);
        chk(sr.action.nbr_pointer, 8'hc3);
        chk(sr.usable, 1'b1);
        chk(dr.hit, 1'b1);
        chk(dr.index, 8'h02);
        chk(dr.usable, 1'b0);
        chk(dr.action.act_type, lkf_pkg::ACT_RESERVED);
        // shorter prefix only; destination misses
        look(1'b0, 1'b0, 128'h0a01_02f0, 128'h0b00_0000);
        chk(sr.index, 8'h03);
        chk(sr.action.act_type, lkf_pkg::ACT_NBR_POINTER);
        chk(sr.action.remap_enable, 1'b1);
        chk(sr.action.equal_cost_path_count, 4'h9);
        chk(sr.action.route_group_id, 3'h5);
        chk(sr.key_type, lkf_pkg::SINGLE_V4_KEY);
        chk(dr.hit, 1'b0);
        // double v4 multicast, exact and catch-all
        u_sw.put(4'h5, lkf_pkg::DOUBLE_V4_KEY, 9'h040,
                 u_sw.dkey(1'b0, 128'h0a00_0001, 128'he000_0001),
                 u_sw.a_mc(2'h1, 8'h77));
        u_sw.put(4'h6, lkf_pkg::DOUBLE_V4_KEY, 9'h000, 256'h0,
                 u_sw.a_mc(2'h1, 8'h33));
        look(1'b0, 1'b1, 128'h0a00_0001, 128'he000_0001);
        chk(dr.index, 8'h05);
        chk(dr.action.multicast_pointer, 8'h77);
        chk(dr.usable, 1'b1);
        chk(sr.hit, 1'b0);
        look(1'b0, 1'b1, 128'he000_0001, 128'h0a00_0001);
        chk(dr.index, 8'h06);
        chk(dr.action.multicast_pointer, 8'h33);
        // single v6 destination with inline neighbour entry
        u_sw.put(4'h9, lkf_pkg::SINGLE_V6_KEY, 9'h081, u_sw.skey(1'b1, V6A),
                 u_sw.a_ne(16'ha1b2, 32'hc3d4_e5f6, 5'h13, 3'h4, 4'hd));
        look(1'b1, 1'b0, V6A, V6A);
        chk(sr.hit, 1'b0);
        chk(dr.index, 8'h09);
        chk(dr.key_type, lkf_pkg::SINGLE_V6_KEY);
        chk(dr.usable, 1'b1);
        chk(dr.action.mac_upper, 16'ha1b2);
        chk(dr.action.mac_lower, 32'hc3d4_e5f6);
        chk(dr.action.router_leg_id, 5'h13);
        chk(dr.action.zero_dmac_cpu_queue, 3'h4);
        chk({dr.action.entry_enable, dr.action.mac_security_match,
             dr.action.vmid_security_match,
             dr.action.reverse_path_check_enable}, 4'hd);
        // double v6, source then destination order
        u_sw.put(4'ha, lkf_pkg::DOUBLE_V6_KEY, 9'h100,
                 u_sw.dkey(1'b1, V6A, V6B), u_sw.a_mc(2'h1, 8'h9c));
        look(1'b1, 1'b1, V6A, V6B);
        chk(dr.index, 8'h0a);
        chk(dr.key_type, lkf_pkg::DOUBLE_V6_KEY);
        chk(dr.action.multicast_pointer, 8'h9c);
        look(1'b1, 1'b1, V6B, V6A);
        chk(dr.hit, 1'b0);
        conclude();
    end
endmodule : testbench
